// ==== verilog/rac_bank.sv ====
/*
 * rac_bank: nonvolatile range, slave address and monitor shift bank.
 * Holds the byte registers, answers byte reads and writes from the serial
 * bus logic, restores values from nonvolatile storage and reports each
 * accepted write for programming into it.
 * Assumes: bus logic, password compare and nonvolatile storage run on
 * clk_sys and hand over single-cycle strobes.
 */
//
// Contract
// RULE_01: bits 2:0 of the swing range register pick the modulation DAC full scale, 000b largest.
// RULE_02: bits 6:4 of the comparison range register pick the bias quick-trip full scale.
// RULE_03: bits 2:0 of the comparison range register pick the power-loop full scale.
// RULE_04: with address select set, main memory answers at the programmed slave address.
// RULE_05: a programmed slave address of A0h disables the auxiliary memory.
// RULE_06: monitor one and two results are right-shifted by fields 6:4 and 2:0 of the first shift register.
// RULE_07: monitor three and four results are right-shifted by the second shift register, default 30h.
// RULE_08: reads and writes need level-two password access, writes persist, reserved bits read zero.
// RULE_09: with address select clear, main memory answers at its default address.
`timescale 1ns/1ps
module rac_bank (
	input wire logic clk_sys, // system clock
	input wire logic rst, // asynchronous reset, active high
	input wire logic ce, // clock enable, freezes all state when low
	input wire logic [7:0] mem_addr, // byte offset of the access
	input wire logic mem_wr, // write strobe
	input wire logic [7:0] mem_wdata, // write data
	input wire logic mem_rd, // read strobe
	output logic [7:0] mem_rdata, // read data
	output logic mem_rvalid, // read data valid pulse
	output logic mem_hit, // offset belongs to this bank
	input wire logic level_two_password, // level-two access granted
	input wire logic nv_load, // restore strobe from storage
	input wire logic [7:0] nv_load_addr, // restore offset
	input wire logic [7:0] nv_load_data, // restore data
	output logic nv_wr, // program strobe to storage
	output logic [7:0] nv_wr_addr, // program offset
	output logic [7:0] nv_wr_data, // program data
	input wire logic alt_addr_select, // address select bit of config
	input wire logic [7:0] bus_addr_byte, // received slave address byte
	output logic [7:0] main_addr, // main memory slave address
	output logic aux_enable, // auxiliary memory enabled
	output logic main_hit, // address byte selects main memory
	output logic aux_hit, // address byte selects auxiliary memory
	output rac_pkg::rac_ranges_s ranges, // full-scale range codes
	output rac_pkg::rac_shifts_s shifts, // monitor shift codes
	input wire logic mon_in_valid, // raw monitor results valid
	input rac_pkg::rac_mon_s mon_in, // raw monitor results
	output logic mon_out_valid, // shifted results valid pulse
	output rac_pkg::rac_mon_s mon_out // shifted results
);

	rac_pkg::rac_bank_state_s st_reg;
	rac_pkg::rac_bank_state_s st_next;
	rac_pkg::rac_mon_s mon_shifted;
	logic wr_ok;
	logic rd_ok;

	// stored bytes carry only writable bits, so reserved bits can never leak out
	function automatic logic [7:0] wmask(input logic [7:0] off);
		case (off)
			rac_pkg::OFF_SWING: wmask = rac_pkg::MASK_SWING;
			rac_pkg::OFF_ALT_ADDR: wmask = rac_pkg::MASK_ALT_ADDR;
			rac_pkg::OFF_TRIP: wmask = rac_pkg::MASK_PAIR;
			rac_pkg::OFF_SHIFT_FIRST: wmask = rac_pkg::MASK_PAIR;
			rac_pkg::OFF_SHIFT_SECOND: wmask = rac_pkg::MASK_PAIR;
			default: wmask = rac_pkg::BYTE_ZERO;
		endcase
	endfunction : wmask

	function automatic logic in_bank(input logic [7:0] off);
		in_bank = (off >= rac_pkg::OFF_SPARE) && (off <= rac_pkg::OFF_SHIFT_SECOND);
	endfunction : in_bank

	function automatic logic [7:0] rd_byte(input rac_pkg::rac_bank_state_s s,
		input logic [7:0] off);
		case (off)
			rac_pkg::OFF_SWING: rd_byte = s.swing;
			rac_pkg::OFF_ALT_ADDR: rd_byte = s.alt_addr;
			rac_pkg::OFF_TRIP: rd_byte = s.trip;
			rac_pkg::OFF_SHIFT_FIRST: rd_byte = s.shift_first;
			rac_pkg::OFF_SHIFT_SECOND: rd_byte = s.shift_second;
			default: rd_byte = rac_pkg::BYTE_ZERO;
		endcase
	endfunction : rd_byte

	assign mem_hit = in_bank(mem_addr);
	assign wr_ok = mem_wr && mem_hit && level_two_password; // RULE_08
	assign rd_ok = mem_rd && mem_hit;

	always_comb begin
		st_next = st_reg;
		st_next.rvalid = 1'b0;
		st_next.nv_pulse = 1'b0;
		st_next.mon_valid = 1'b0;
		// restore first so a host write in the same cycle overrides it
		if (nv_load && in_bank(nv_load_addr)) begin
			case (nv_load_addr)
				rac_pkg::OFF_SWING: st_next.swing = nv_load_data & rac_pkg::MASK_SWING;
				rac_pkg::OFF_ALT_ADDR: st_next.alt_addr = nv_load_data;
				rac_pkg::OFF_TRIP: st_next.trip = nv_load_data & rac_pkg::MASK_PAIR;
				rac_pkg::OFF_SHIFT_FIRST: begin
					st_next.shift_first = nv_load_data & rac_pkg::MASK_PAIR;
				end
				rac_pkg::OFF_SHIFT_SECOND: begin
					st_next.shift_second = nv_load_data & rac_pkg::MASK_PAIR;
				end
				default: st_next.swing = st_next.swing;
			endcase
		end
		if (wr_ok) begin
			case (mem_addr)
				rac_pkg::OFF_SWING: st_next.swing = mem_wdata & wmask(mem_addr); // RULE_08
				rac_pkg::OFF_ALT_ADDR: st_next.alt_addr = mem_wdata & wmask(mem_addr);
				rac_pkg::OFF_TRIP: st_next.trip = mem_wdata & wmask(mem_addr); // RULE_08
				rac_pkg::OFF_SHIFT_FIRST: begin
					st_next.shift_first = mem_wdata & wmask(mem_addr);
				end
				rac_pkg::OFF_SHIFT_SECOND: begin
					st_next.shift_second = mem_wdata & wmask(mem_addr);
				end
				default: st_next.swing = st_next.swing;
			endcase
			// every accepted write is handed on for programming
			st_next.nv_pulse = 1'b1; // RULE_08
			st_next.nv_addr = mem_addr;
			st_next.nv_data = mem_wdata & wmask(mem_addr);
		end
		if (rd_ok) begin
			st_next.rvalid = 1'b1;
			// without access a read returns zero rather than stalling the bus
			if (level_two_password) begin
				st_next.rdata = rd_byte(st_reg, mem_addr); // RULE_08
			end else begin
				st_next.rdata = rac_pkg::BYTE_ZERO; // RULE_08
			end
		end
		if (mon_in_valid) begin
			st_next.mon = mon_shifted;
			st_next.mon_valid = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_reg.swing <= rac_pkg::RST_SWING;
			st_reg.alt_addr <= rac_pkg::RST_ALT_ADDR;
			st_reg.trip <= rac_pkg::RST_TRIP;
			st_reg.shift_first <= rac_pkg::RST_SHIFT_FIRST;
			st_reg.shift_second <= rac_pkg::RST_SHIFT_SECOND; // RULE_07
			st_reg.rdata <= rac_pkg::BYTE_ZERO;
			st_reg.rvalid <= 1'b0;
			st_reg.nv_pulse <= 1'b0;
			st_reg.nv_addr <= rac_pkg::BYTE_ZERO;
			st_reg.nv_data <= rac_pkg::BYTE_ZERO;
			st_reg.mon <= '0;
			st_reg.mon_valid <= 1'b0;
		end else if (ce) begin
			st_reg <= st_next;
		end
	end

	always_comb begin
		ranges.swing_dac_range = rac_pkg::rac_field(st_reg.swing, rac_pkg::FLD_LO_LSB); // RULE_01
		ranges.bias_trip_range = rac_pkg::rac_field(st_reg.trip, rac_pkg::FLD_HI_LSB); // RULE_02
		ranges.power_loop_range = rac_pkg::rac_field(st_reg.trip, rac_pkg::FLD_LO_LSB); // RULE_03
		shifts.monitor_one_shift =
			rac_pkg::rac_field(st_reg.shift_first, rac_pkg::FLD_HI_LSB); // RULE_06
		shifts.monitor_two_shift =
			rac_pkg::rac_field(st_reg.shift_first, rac_pkg::FLD_LO_LSB); // RULE_06
		shifts.monitor_three_shift =
			rac_pkg::rac_field(st_reg.shift_second, rac_pkg::FLD_HI_LSB); // RULE_07
		shifts.monitor_four_shift =
			rac_pkg::rac_field(st_reg.shift_second, rac_pkg::FLD_LO_LSB); // RULE_07
	end

	rac_mon_shift u_shift (
		.mon_in(mon_in),
		.shifts(shifts),
		.mon_out(mon_shifted)
	);

	rac_addr_match u_addr (
		.alt_addr_select(alt_addr_select),
		.alt_slave_address(st_reg.alt_addr),
		.bus_addr_byte(bus_addr_byte),
		.main_addr(main_addr),
		.aux_enable(aux_enable),
		.main_hit(main_hit),
		.aux_hit(aux_hit)
	);

	assign mem_rdata = st_reg.rdata;
	assign mem_rvalid = st_reg.rvalid;
	assign nv_wr = st_reg.nv_pulse;
	assign nv_wr_addr = st_reg.nv_addr;
	assign nv_wr_data = st_reg.nv_data;
	assign mon_out_valid = st_reg.mon_valid;
	assign mon_out = st_reg.mon;

endmodule : rac_bank

// ==== verilog/rac_pkg.sv ====
/*
 * rac_pkg: shared constants and carrier types of the range and address
 * configuration bank.
 * Assumes: one byte-wide memory port into the bank and 16-bit monitor results.
 */
package rac_pkg;

	// byte offsets of the bank
	localparam logic [7:0] OFF_SPARE = 8'h8a;
	localparam logic [7:0] OFF_SWING = 8'h8b;
	localparam logic [7:0] OFF_ALT_ADDR = 8'h8c;
	localparam logic [7:0] OFF_TRIP = 8'h8d;
	localparam logic [7:0] OFF_SHIFT_FIRST = 8'h8e;
	localparam logic [7:0] OFF_SHIFT_SECOND = 8'h8f;

	// factory defaults
	localparam logic [7:0] RST_SWING = 8'h00;
	localparam logic [7:0] RST_ALT_ADDR = 8'h00;
	localparam logic [7:0] RST_TRIP = 8'h00;
	localparam logic [7:0] RST_SHIFT_FIRST = 8'h00;
	localparam logic [7:0] RST_SHIFT_SECOND = 8'h30;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	// writable bits; all others are reserved and read as zero
	localparam logic [7:0] MASK_SWING = 8'h07;
	localparam logic [7:0] MASK_ALT_ADDR = 8'hff;
	localparam logic [7:0] MASK_PAIR = 8'h77;

	// two 3-bit fields per paired register
	localparam int FLD_HI_LSB = 4;
	localparam int FLD_LO_LSB = 0;
	localparam int CODE_W = 3;

	// serial slave addresses, r/w bit excluded by comparison mask
	localparam logic [7:0] ADDR_MAIN_DEFAULT = 8'ha2;
	localparam logic [7:0] ADDR_AUX = 8'ha0;
	localparam logic [7:0] ADDR_AUX_DISABLE = 8'ha0;
	localparam logic [7:0] ADDR_CMP_MASK = 8'hfe;

	localparam int MON_W = 16;

	typedef logic [CODE_W-1:0] rac_code_t;
	typedef logic [MON_W-1:0] rac_mon_t;

	typedef struct packed {
		rac_code_t swing_dac_range;
		rac_code_t bias_trip_range;
		rac_code_t power_loop_range;
	} rac_ranges_s;

	typedef struct packed {
		rac_code_t monitor_one_shift;
		rac_code_t monitor_two_shift;
		rac_code_t monitor_three_shift;
		rac_code_t monitor_four_shift;
	} rac_shifts_s;

	typedef struct packed {
		rac_mon_t one;
		rac_mon_t two;
		rac_mon_t three;
		rac_mon_t four;
	} rac_mon_s;

	typedef struct packed {
		logic [7:0] swing;
		logic [7:0] alt_addr;
		logic [7:0] trip;
		logic [7:0] shift_first;
		logic [7:0] shift_second;
		logic [7:0] rdata;
		logic rvalid;
		logic nv_pulse;
		logic [7:0] nv_addr;
		logic [7:0] nv_data;
		rac_mon_s mon;
		logic mon_valid;
	} rac_bank_state_s;

	function automatic rac_code_t rac_field(input logic [7:0] b, input int lsb);
		rac_field = b[lsb +: CODE_W];
	endfunction : rac_field

endpackage : rac_pkg

// ==== verilog/rac_addr_match.sv ====
/*
 * rac_addr_match: picks the main-memory slave address and decides which
 * memory space an incoming address byte selects.
 * Assumes: address byte comes from bus logic on the same clock.
 */
`timescale 1ns/1ps
module rac_addr_match (
	input wire logic alt_addr_select, // use programmed main address
	input wire logic [7:0] alt_slave_address, // programmed address byte
	input wire logic [7:0] bus_addr_byte, // received address byte, bit 0 is r/w
	output logic [7:0] main_addr, // address the main memory answers at
	output logic aux_enable, // auxiliary memory still answers
	output logic main_hit, // address byte selects main memory
	output logic aux_hit // address byte selects auxiliary memory
);

	always_comb begin
		if (alt_addr_select) begin
			main_addr = alt_slave_address; // RULE_04
		end else begin
			main_addr = rac_pkg::ADDR_MAIN_DEFAULT; // RULE_09
		end
		aux_enable = (alt_slave_address != rac_pkg::ADDR_AUX_DISABLE); // RULE_05
		main_hit = ((bus_addr_byte & rac_pkg::ADDR_CMP_MASK)
			== (main_addr & rac_pkg::ADDR_CMP_MASK));
		// main space wins if both would match
		aux_hit = aux_enable && !main_hit
			&& ((bus_addr_byte & rac_pkg::ADDR_CMP_MASK) == rac_pkg::ADDR_AUX); // RULE_05
	end

endmodule : rac_addr_match

// ==== verilog/rac_mon_shift.sv ====
/*
 * rac_mon_shift: right-shifts the four monitor results by their own codes.
 * Assumes: the caller registers the outputs.
 */
`timescale 1ns/1ps
module rac_mon_shift (
	input rac_pkg::rac_mon_s mon_in, // raw final results
	input rac_pkg::rac_shifts_s shifts, // per-channel shift codes
	output rac_pkg::rac_mon_s mon_out // weighted results
);

	function automatic rac_pkg::rac_mon_t shr(input rac_pkg::rac_mon_t v,
		input rac_pkg::rac_code_t n);
		shr = v >> n;
	endfunction : shr

	always_comb begin
		mon_out.one = shr(mon_in.one, shifts.monitor_one_shift); // RULE_06
		mon_out.two = shr(mon_in.two, shifts.monitor_two_shift); // RULE_06
		mon_out.three = shr(mon_in.three, shifts.monitor_three_shift); // RULE_07
		mon_out.four = shr(mon_in.four, shifts.monitor_four_shift); // RULE_07
	end

endmodule : rac_mon_shift

// ==== tb/rac_checker.sv ====
/* rac_checker: port-level assertions for rac_bank.
   Assumes one clock domain and is attached by the bind at the foot. */
`timescale 1ns/1ps
module rac_checker (
	input logic clk_sys, // clock
	input logic rst, // reset
	input logic ce, // enable
	input logic [7:0] mem_addr, // offset
	input logic mem_wr, // write
	input logic mem_rd, // read
	input logic [7:0] mem_rdata, // read data
	input logic mem_rvalid, // read valid
	input logic mem_hit, // in bank
	input logic level_two_password, // access
	input logic nv_wr, // program strobe
	input logic [7:0] nv_wr_addr, // program offset
	input logic alt_addr_select, // select
	input logic [7:0] bus_addr_byte, // slave byte
	input logic [7:0] main_addr, // main address
	input logic aux_enable, // aux on
	input logic main_hit, // main match
	input logic aux_hit, // aux match
	input logic mon_in_valid, // raw valid
	input rac_pkg::rac_mon_s mon_in, // raw
	input logic mon_out_valid, // out valid
	input rac_pkg::rac_mon_s mon_out, // out
	input rac_pkg::rac_shifts_s shifts // codes
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	sequence s_rd;
		ce && mem_rd && mem_hit;
	endsequence
	sequence s_wr;
		ce && mem_wr && mem_hit && level_two_password;
	endsequence
	sequence s_mon;
		ce && mon_in_valid;
	endsequence
	property p_rd; s_rd |=> mem_rvalid; endproperty
	property p_rd_idle; ce && !(mem_rd && mem_hit) |=> !mem_rvalid; endproperty
	property p_lock; s_rd ##0 !level_two_password |=> mem_rdata == 8'h00; endproperty
	property p_wr; s_wr |=> nv_wr && nv_wr_addr == $past(mem_addr); endproperty
	property p_wr_idle; ce && !(mem_wr && mem_hit && level_two_password) |=> !nv_wr; endproperty
	property p_hit; mem_hit == (mem_addr >= 8'h8a && mem_addr <= 8'h8f); endproperty
	property p_default; !alt_addr_select |-> main_addr == 8'ha2; endproperty
	property p_aux_off; alt_addr_select |-> aux_enable == (main_addr != 8'ha0); endproperty
	property p_main_hit; main_hit == (bus_addr_byte[7:1] == main_addr[7:1]); endproperty
	property p_aux_hit; aux_hit |-> aux_enable && !main_hit && bus_addr_byte[7:1] == 7'h50;
	endproperty
	property p_mon;
		s_mon |=> mon_out_valid
			&& mon_out.one == ($past(mon_in.one) >> $past(shifts.monitor_one_shift))
			&& mon_out.four == ($past(mon_in.four) >> $past(shifts.monitor_four_shift));
	endproperty
	a_rd: assert property (p_rd) else $error("read not answered");
	a_rd_idle: assert property (p_rd_idle) else $error("stray read valid");
	a_lock: assert property (p_lock) else $error("locked read not zero");
	a_wr: assert property (p_wr) else $error("write not programmed");
	a_wr_idle: assert property (p_wr_idle) else $error("stray program strobe");
	a_hit: assert property (p_hit) else $error("bank offset decode wrong");
	a_default: assert property (p_default) else $error("default address wrong");
	a_aux_off: assert property (p_aux_off) else $error("aux enable wrong");
	a_main_hit: assert property (p_main_hit) else $error("main match wrong");
	a_aux_hit: assert property (p_aux_hit) else $error("aux match wrong");
	a_mon: assert property (p_mon) else $error("monitor shift wrong");
endmodule : rac_checker
bind rac_bank rac_checker u_chk (.clk_sys, .rst, .ce, .mem_addr, .mem_wr, .mem_rd, .mem_rdata,
	.mem_rvalid, .mem_hit, .level_two_password, .nv_wr, .nv_wr_addr, .alt_addr_select,
	.bus_addr_byte, .main_addr, .aux_enable, .main_hit, .aux_hit, .mon_in_valid, .mon_in,
	.mon_out_valid, .mon_out, .shifts);

// ==== tb/rac_host_model.sv ====
/* rac_host_model: host side of the byte port, one strobe per access.
   Assumes answers are registered at the taking edge and read half a cycle later. */
`timescale 1ns/1ps
module rac_host_model (
	input logic clk_sys, // clock
	output logic [7:0] mem_addr, // offset
	output logic mem_wr, // write strobe
	output logic [7:0] mem_wdata, // write data
	output logic mem_rd, // read strobe
	input logic [7:0] mem_rdata, // read data
	input logic mem_rvalid // read valid
);
	initial begin
		mem_addr = 8'h00;
		mem_wr = 1'b0;
		mem_wdata = 8'h00;
		mem_rd = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		mem_addr = a;
		mem_wdata = d;
		mem_wr = 1'b1;
		@(negedge clk_sys);
		mem_wr = 1'b0;
		// released data flipped so a stale byte is never mistaken for fresh
		mem_wdata = ~d;
		mem_addr = 8'h00;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_sys);
		mem_addr = a;
		mem_rd = 1'b1;
		@(negedge clk_sys);
		mem_rd = 1'b0;
		mem_addr = 8'h00;
		d = mem_rvalid ? mem_rdata : 8'hxx;
	endtask : rd
endmodule : rac_host_model

// ==== tb/tb_top.sv ====
/* tb_top: self-checking bench for rac_bank.
   Assumes rac_host_model drives the byte port and the checker is bound. */
`timescale 1ns/1ps
module tb_top;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic level_two_password = 1'b1;
	logic nv_load = 1'b0;
	logic [7:0] nv_load_addr = 8'h00;
	logic [7:0] nv_load_data = 8'h00;
	logic alt_addr_select = 1'b0;
	logic [7:0] bus_addr_byte = 8'h00;
	logic mon_in_valid = 1'b0;
	rac_pkg::rac_mon_s mon_in = '0;
	logic [7:0] mem_addr, mem_wdata, mem_rdata, nv_wr_addr, nv_wr_data, main_addr, rd;
	logic mem_wr, mem_rd, mem_rvalid, mem_hit, nv_wr, aux_enable, main_hit, aux_hit;
	logic mon_out_valid;
	rac_pkg::rac_ranges_s ranges;
	rac_pkg::rac_shifts_s shifts;
	rac_pkg::rac_mon_s mon_out;
	int fails = 0;
	int checked = 0;
	always #2.5 clk_sys = ~clk_sys;
	rac_host_model host (.clk_sys, .mem_addr, .mem_wr, .mem_wdata, .mem_rd, .mem_rdata,
		.mem_rvalid);
	rac_bank DUT (.clk_sys, .rst, .ce, .mem_addr, .mem_wr, .mem_wdata, .mem_rd, .mem_rdata,
		.mem_rvalid, .mem_hit, .level_two_password, .nv_load, .nv_load_addr, .nv_load_data,
		.nv_wr, .nv_wr_addr, .nv_wr_data, .alt_addr_select, .bus_addr_byte, .main_addr,
		.aux_enable, .main_hit, .aux_hit, .ranges, .shifts, .mon_in_valid, .mon_in,
		.mon_out_valid, .mon_out);
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		checked++;
		if (s !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic close_out;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : close_out
	task automatic t_defaults;
		logic [7:0] e [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h30};
		for (int i = 0; i < 6; i++) begin
			host.rd(8'h8a + 8'(i), rd);
			chk("reset value", 16'(rd), 16'(e[i]));
		end
	endtask : t_defaults
	task automatic t_masks;
		logic [7:0] m [6] = '{8'h00, 8'h07, 8'hff, 8'h77, 8'h77, 8'h77};
		for (int i = 0; i < 6; i++) begin
			host.wr(8'h8a + 8'(i), 8'hff);
			chk("program strobe", 16'(nv_wr), 16'h0001);
			chk("program data", 16'(nv_wr_data), 16'(m[i]));
			host.rd(8'h8a + 8'(i), rd);
			chk("read back", 16'(rd), 16'(m[i]));
		end
	endtask : t_masks
	task automatic t_ranges;
		host.wr(8'h8b, 8'h05);
		host.wr(8'h8d, 8'h63);
		chk("swing range", 16'(ranges.swing_dac_range), 16'h0005);
		chk("bias range", 16'(ranges.bias_trip_range), 16'h0006);
		chk("power range", 16'(ranges.power_loop_range), 16'h0003);
		level_two_password = 1'b0;
		host.wr(8'h8b, 8'h02);
		chk("refused strobe", 16'(nv_wr), 16'h0000);
		host.rd(8'h8b, rd);
		chk("locked read", 16'(rd), 16'h0000);
		level_two_password = 1'b1;
		chk("kept range", 16'(ranges.swing_dac_range), 16'h0005);
		// an offset just past the bank must not reach storage
		host.wr(8'h90, 8'h55);
		chk("outside strobe", 16'(nv_wr), 16'h0000);
	endtask : t_ranges
	task automatic t_addr;
		host.wr(8'h8c, 8'h5a);
		bus_addr_byte = 8'ha3;
		#1 chk("default addr", 16'(main_addr), 16'h00a2);
		chk("default hit", 16'(main_hit), 16'h0001);
		@(negedge clk_sys);
		alt_addr_select = 1'b1;
		bus_addr_byte = 8'h5b;
		#1 chk("alt addr", 16'(main_addr), 16'h005a);
		chk("alt hit", 16'(main_hit), 16'h0001);
		@(negedge clk_sys);
		bus_addr_byte = 8'ha0;
		#1 chk("aux hit", 16'(aux_hit), 16'h0001);
		@(negedge clk_sys);
		nv_load = 1'b1;
		nv_load_addr = 8'h8c;
		nv_load_data = 8'ha0;
		@(negedge clk_sys);
		nv_load = 1'b0;
		// default main address, so only the disable can hold aux_hit low
		alt_addr_select = 1'b0;
		#1 chk("aux enable", 16'(aux_enable), 16'h0000);
		chk("aux hit off", 16'(aux_hit), 16'h0000);
	endtask : t_addr
	task automatic t_mon;
		host.wr(8'h8e, 8'h21);
		host.wr(8'h8f, 8'h74);
		mon_in = {16'hf00f, 16'h8001, 16'hffff, 16'h1234};
		ce = 1'b0;
		mon_in_valid = 1'b1;
		@(negedge clk_sys);
		chk("frozen valid", 16'(mon_out_valid), 16'h0000);
		ce = 1'b1;
		@(negedge clk_sys);
		mon_in_valid = 1'b0;
		chk("mon valid", 16'(mon_out_valid), 16'h0001);
		chk("mon one", mon_out.one, 16'h3c03);
		chk("mon two", mon_out.two, 16'h4000);
		chk("mon three", mon_out.three, 16'h01ff);
		chk("mon four", mon_out.four, 16'h0123);
	endtask : t_mon
	initial begin
		repeat (12) @(posedge clk_sys);
		@(negedge clk_sys);
		rst = 1'b0;
		t_defaults();
		t_masks();
		t_ranges();
		t_addr();
		t_mon();
		// mid-run reset must bring the defaults back
		rst = 1'b1;
		@(negedge clk_sys);
		rst = 1'b0;
		t_defaults();
		close_out();
	end
	initial begin
		#20000;
		fails++;
		close_out();
	end
endmodule : tb_top
